//--- hdl/ssel_pkg.sv
// Shared constants, codes and carrier structs for the speed reference source selector.
// Assumes a single 25 MHz clock and a plain address/strobe register port.
package ssel_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port geometry and offsets
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 16;
    localparam logic [3:0]  OFS_CTRL    = 4'h0;
    localparam logic [3:0]  OFS_CFG     = 4'h1;
    localparam logic [3:0]  OFS_KEYPAD  = 4'h2;
    localparam logic [3:0]  OFS_PRESET1 = 4'h3;
    localparam logic [3:0]  OFS_STATUS  = 4'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_AN2 = 0;
    localparam int CTRL_PRE = 1;
    localparam int CTRL_KEY = 2;
    localparam int CTRL_PRC = 3;
    localparam int CTRL_SB0 = 4;
    localparam int CTRL_SB1 = 5;
    localparam int CTRL_SB2 = 6;
    localparam int CTRL_RST = 7;
    localparam logic [15:0] CTRL_WMASK = 16'h00ff;

    // Configuration register fields
    localparam int CFG_REFSEL_LSB = 0;
    localparam int CFG_AN2MODE    = 3;
    localparam int CFG_PSEL_LSB   = 4;
    localparam int CFG_INIT_LSB   = 8;
    localparam logic [15:0] CFG_WMASK = 16'h03ff;

    // Status register fields
    localparam int STAT_SRC_LSB = 0;
    localparam int STAT_PRE_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] CTRL_RST_VAL   = 16'h0000;
    localparam logic [15:0] CFG_RST_VAL    = 16'h0000;
    localparam logic [15:0] VALUE_RST_VAL  = 16'h0000;
    localparam logic [3:0]  PRE_IND_RST    = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Codes
    typedef enum logic [2:0] {
        SRC_AN1       = 3'h1,
        SRC_AN2       = 3'h2,
        SRC_PRESET    = 3'h3,
        SRC_KEYPAD    = 3'h4,
        SRC_PRECISION = 3'h5
    } ssel_src_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'h1,
        ST_RUN  = 2'h2
    } ssel_fsm_t;

    localparam logic [1:0] INIT_ZERO    = 2'h0;
    localparam logic [1:0] INIT_LAST    = 2'h1;
    localparam logic [1:0] INIT_PRESET1 = 2'h2;
    localparam logic [3:0] PSEL_BITS    = 4'h0;
    localparam logic [3:0] PSEL_TIMED   = 4'h9;
    localparam logic [2:0] REFSEL_TERM  = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int TICK_PERIOD_US = 4000;
    localparam int CLK_FREQ_MHZ   = 25;
    localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_FREQ_MHZ;
    localparam int TICK_CNT_W     = 17;
    localparam logic [15:0] DWELL_TICKS = 16'h00fa;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers and state
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
    } ssel_bus_req_t;

    typedef struct packed {
        logic [15:0] keypad;
        logic [15:0] preset1;
        logic [1:0]  init_sel;
    } ssel_nv_t;

    typedef struct packed {
        ssel_fsm_t   fsm;
        logic [15:0] ctrl;
        logic [15:0] cfg;
        logic [15:0] keypad;
        logic [15:0] preset1;
        ssel_src_t   src;
        logic [3:0]  pre_ind;
        logic [2:0]  seq_idx;
        logic [15:0] dwell;
        logic [15:0] rdata;
    } ssel_state_t;

    typedef struct packed {
        logic [TICK_CNT_W-1:0] cnt;
        logic                  tick;
    } ssel_tick_state_t;

endpackage : ssel_pkg

//--- hdl/ssel_tick.sv
// Divider that turns the system clock into a one-cycle control-task enable.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/1ns
module ssel_tick #(
    parameter int CNT = ssel_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    // Enable pulse
    output logic      tick_o
);
    import ssel_pkg::*;

    ssel_tick_state_t q, d;

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt == TICK_CNT_W'(CNT - 1)) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + TICK_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

    tick_period_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        q.tick |-> q.cnt == '0)
        else $error("tick not aligned to divider wrap");

endmodule : ssel_tick

//--- hdl/ssel_top.sv
// Speed reference source selector: override priority, preset number, sequencing timer,
// power-up keypad value and a small register file.
// Assumes synchronous inputs, a plain register port and restored values on nv_i at reset.
//
// Function
// - Highest of four overrides wins, precision first
// - Analog-2 override alone forces source 2
// - Preset override over analog-2 forces source 3
// - Keypad override without precision forces source 4
// - Precision override always forces source 5
// - Three select bits form preset number bits
// - Restart flag holds timer, selects preset 1
// - Restart clear: preset follows sequencing timer
// - Active source indicator 1..5, 4ms refresh
// - Active preset indicator reads 1..8
// - Power-up keypad value: zero, last, preset1
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ns
module ssel_top #(
    parameter int          TICK_CNT = ssel_pkg::TICK_CYCLES,
    parameter logic [15:0] DWELL    = ssel_pkg::DWELL_TICKS
) (
    // Clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   nrst_i,
    // Register port
    input  wire ssel_pkg::ssel_bus_req_t bus_i,
    output logic [15:0]                 rdata_o,
    // Values restored at power-up
    input  wire ssel_pkg::ssel_nv_t     nv_i,
    // Indicators and values
    output ssel_pkg::ssel_src_t         active_source_indicator_o,
    output logic [3:0]                  active_preset_indicator_o,
    output logic [15:0]                 keypad_reference_value_o,
    output logic [15:0]                 first_preset_value_o
);
    import ssel_pkg::*;

    ssel_state_t q, d;
    logic        tick;
    logic        ovr_an2;
    logic        ovr_pre;
    logic        ovr_key;
    logic        ovr_prc;
    logic        restart;
    logic [2:0]  sel_bits;
    logic [2:0]  refsel;
    logic        an2_mode;
    logic [3:0]  psel;
    logic        timed;
    logic [15:0] status;

    ////////////////////////////////////////////////////////////////////////////
    // Control task enable
    ssel_tick #(
        .CNT       (TICK_CNT)
    ) u_tick (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .tick_o    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    assign ovr_an2  = q.ctrl[CTRL_AN2];
    assign ovr_pre  = q.ctrl[CTRL_PRE];
    assign ovr_key  = q.ctrl[CTRL_KEY];
    assign ovr_prc  = q.ctrl[CTRL_PRC];
    assign restart  = q.ctrl[CTRL_RST];
    assign sel_bits = {q.ctrl[CTRL_SB2], q.ctrl[CTRL_SB1], q.ctrl[CTRL_SB0]};
    assign refsel   = q.cfg[CFG_REFSEL_LSB +: 3];
    assign an2_mode = q.cfg[CFG_AN2MODE];
    assign psel     = q.cfg[CFG_PSEL_LSB +: 4];
    assign timed    = (psel == PSEL_TIMED);

    // Status word as software reads it
    always_comb begin
        status                     = '0;
        status[STAT_SRC_LSB +: 3]  = q.src;
        status[STAT_PRE_LSB +: 4]  = q.pre_ind;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d       = q;
        d.rdata = '0;

        // Register writes
        if (bus_i.we) begin
            case (bus_i.addr)
                OFS_CTRL:    d.ctrl    = bus_i.wdata & CTRL_WMASK;
                OFS_CFG:     d.cfg     = bus_i.wdata & CFG_WMASK;
                OFS_KEYPAD:  d.keypad  = bus_i.wdata;
                OFS_PRESET1: d.preset1 = bus_i.wdata;
                default:     d.ctrl    = q.ctrl;
            endcase
        end

        // Register reads; unmapped offsets answer zero
        if (bus_i.re) begin
            case (bus_i.addr)
                OFS_CTRL:    d.rdata = q.ctrl;
                OFS_CFG:     d.rdata = q.cfg;
                OFS_KEYPAD:  d.rdata = q.keypad;
                OFS_PRESET1: d.rdata = q.preset1;
                OFS_STATUS:  d.rdata = status;
                default:     d.rdata = '0;
            endcase
        end

        case (q.fsm)
            ST_LOAD: begin
                // First cycle after reset: restore keypad value per stored option
                d.fsm                      = ST_RUN;
                d.cfg[CFG_INIT_LSB +: 2]   = nv_i.init_sel;
                d.preset1                  = nv_i.preset1;
                case (nv_i.init_sel)
                    INIT_LAST:    d.keypad = nv_i.keypad;
                    INIT_PRESET1: d.keypad = nv_i.preset1;
                    default:      d.keypad = VALUE_RST_VAL;
                endcase
            end
            ST_RUN: begin
                // Sequencing timer; held while restart is set, runs only with the timed preset selector
                if (timed && restart) begin
                    d.dwell   = '0;
                    d.seq_idx = '0;
                end else if (timed && tick) begin
                    if (q.dwell == DWELL - 16'h0001) begin
                        d.dwell   = '0;
                        d.seq_idx = q.seq_idx + 3'h1;
                    end else begin
                        d.dwell = q.dwell + 16'h0001;
                    end
                end

                if (tick) begin
                    // Override priority, highest first
                    if (ovr_prc) begin
                        d.src = SRC_PRECISION;
                    end else if (ovr_key) begin
                        d.src = SRC_KEYPAD;
                    end else if (ovr_pre) begin
                        d.src = SRC_PRESET;
                    end else if (ovr_an2) begin
                        d.src = SRC_AN2;
                    end else if (refsel == REFSEL_TERM) begin
                        d.src = an2_mode ? SRC_AN2 : SRC_AN1;
                    end else if (refsel > 3'h5) begin
                        d.src = SRC_PRECISION;
                    end else begin
                        d.src = ssel_src_t'(refsel);
                    end

                    // Preset number
                    if (timed) begin
                        d.pre_ind = restart ? 4'h1 : {1'b0, q.seq_idx} + 4'h1;
                    end else if (psel == PSEL_BITS) begin
                        d.pre_ind = {1'b0, sel_bits} + 4'h1;
                    end else if (psel <= 4'h8) begin
                        d.pre_ind = psel;
                    end else begin
                        d.pre_ind = PRE_IND_RST;
                    end
                end
            end
            default: begin
                d.fsm = ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            q.fsm     <= ST_LOAD;
            q.ctrl    <= CTRL_RST_VAL;
            q.cfg     <= CFG_RST_VAL;
            q.keypad  <= VALUE_RST_VAL;
            q.preset1 <= VALUE_RST_VAL;
            q.src     <= SRC_AN1;
            q.pre_ind <= PRE_IND_RST;
            q.seq_idx <= '0;
            q.dwell   <= '0;
            q.rdata   <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_o                   = q.rdata;
    assign active_source_indicator_o = q.src;
    assign active_preset_indicator_o = q.pre_ind;
    assign keypad_reference_value_o  = q.keypad;
    assign first_preset_value_o      = q.preset1;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // Most checks apply only once the power-up load is done
    logic run;
    assign run = (q.fsm == ST_RUN);

    prio_prc_a: assert property (
        run && tick && ovr_prc |=> active_source_indicator_o == SRC_PRECISION)
        else $error("precision override did not give source 5");

    prio_key_a: assert property (
        run && tick && ovr_key && !ovr_prc |=> active_source_indicator_o == SRC_KEYPAD)
        else $error("keypad override did not give source 4");

    prio_pre_a: assert property (
        run && tick && ovr_pre && !ovr_key && !ovr_prc
        |=> active_source_indicator_o == SRC_PRESET)
        else $error("preset override did not give source 3");

    prio_an2_a: assert property (
        run && tick && ovr_an2 && !ovr_pre && !ovr_key && !ovr_prc
        |=> active_source_indicator_o == SRC_AN2)
        else $error("analog 2 override did not give source 2");

    prio_order_a: assert property (
        run && tick && ovr_an2 && ovr_prc |=> active_source_indicator_o != SRC_AN2)
        else $error("lower override beat higher one");

    no_override_a: assert property (
        run && tick && !(ovr_an2 || ovr_pre || ovr_key || ovr_prc) && refsel == REFSEL_TERM
        |=> active_source_indicator_o == (an2_mode ? SRC_AN2 : SRC_AN1))
        else $error("terminal source not taken from analog mode");

    sel_bits_a: assert property (
        run && tick && psel == PSEL_BITS
        |=> active_preset_indicator_o == {1'b0, $past(sel_bits)} + 4'h1)
        else $error("preset number does not follow select bits");

    restart_hold_a: assert property (
        run && timed && restart && tick |=> active_preset_indicator_o == 4'h1 && q.dwell == '0)
        else $error("restart flag did not hold preset 1");

    seq_step_a: assert property (
        run && tick && timed && !restart && q.dwell == DWELL - 16'h0001
        |=> q.seq_idx == $past(q.seq_idx) + 3'h1)
        else $error("sequencing timer did not step");

    src_refresh_a: assert property (
        $changed(active_source_indicator_o) |-> $past(tick)
        && active_source_indicator_o >= SRC_AN1 && active_source_indicator_o <= SRC_PRECISION)
        else $error("source indicator changed off the control tick or out of range");

    pre_range_a: assert property (
        active_preset_indicator_o >= 4'h1 && active_preset_indicator_o <= 4'h8)
        else $error("preset indicator out of range");

    restart_dwell_a: assert property (
        run && timed && restart |=> q.dwell == '0 && q.seq_idx == '0)
        else $error("restart flag did not hold the sequencing timer");

    seq_hold_a: assert property (
        run && timed && !restart && !tick |=> $stable(q.dwell) && $stable(q.seq_idx))
        else $error("sequencing timer moved without a control tick");

    // Selector codes 1 to 8 show that preset directly
    pre_fixed_a: assert property (
        run && tick && psel != PSEL_BITS && psel <= 4'h8
        |=> active_preset_indicator_o == $past(psel))
        else $error("fixed preset selector not shown");

    pre_hold_a: assert property (
        !tick |=> $stable(active_preset_indicator_o))
        else $error("preset indicator changed off the control tick");

    // Load checks use the sampled reset: the release edge itself is still a reset cycle
    init_last_a: assert property (
        nrst_i && q.fsm == ST_LOAD && nv_i.init_sel == INIT_LAST
        |=> keypad_reference_value_o == $past(nv_i.keypad))
        else $error("keypad not restored to last value");

    init_zero_a: assert property (
        nrst_i && q.fsm == ST_LOAD && nv_i.init_sel == INIT_ZERO
        |=> keypad_reference_value_o == '0)
        else $error("keypad not cleared at power-up");

    init_preset1_a: assert property (
        nrst_i && q.fsm == ST_LOAD && nv_i.init_sel == INIT_PRESET1
        |=> keypad_reference_value_o == $past(nv_i.preset1))
        else $error("keypad not loaded from preset 1 at power-up");

    init_pre1_reg_a: assert property (
        nrst_i && q.fsm == ST_LOAD |=> first_preset_value_o == $past(nv_i.preset1))
        else $error("preset 1 value not restored at power-up");

    ////////////////////////////////////////////////////////////////////////////
    // Register port checks
    rd_idle_a: assert property (
        !bus_i.re |=> rdata_o == '0)
        else $error("read data not zero outside a read answer");

    rd_status_a: assert property (
        bus_i.re && bus_i.addr == OFS_STATUS
        |=> rdata_o[STAT_SRC_LSB +: 3] == $past(active_source_indicator_o)
        && rdata_o[STAT_PRE_LSB +: 4] == $past(active_preset_indicator_o))
        else $error("status read does not match indicators");

    rd_unmapped_a: assert property (
        bus_i.re && bus_i.addr > OFS_STATUS |=> rdata_o == '0)
        else $error("unmapped read did not answer zero");

    wr_ctrl_a: assert property (
        bus_i.we && bus_i.addr == OFS_CTRL |=> q.ctrl == ($past(bus_i.wdata) & CTRL_WMASK))
        else $error("control write not taken or not masked");

    wr_cfg_a: assert property (
        run && bus_i.we && bus_i.addr == OFS_CFG
        |=> q.cfg == ($past(bus_i.wdata) & CFG_WMASK))
        else $error("configuration write not taken or not masked");

    wr_keypad_a: assert property (
        run && bus_i.we && bus_i.addr == OFS_KEYPAD
        |=> keypad_reference_value_o == $past(bus_i.wdata))
        else $error("keypad write not taken");

    wr_preset1_a: assert property (
        run && bus_i.we && bus_i.addr == OFS_PRESET1
        |=> first_preset_value_o == $past(bus_i.wdata))
        else $error("preset 1 write not taken");

    wr_status_a: assert property (
        run && bus_i.we && bus_i.addr == OFS_STATUS
        |=> $stable(q.ctrl) && $stable(q.cfg))
        else $error("status write disturbed control or configuration");

    // Scenario covers
    cov_prio_c: cover property (run && tick && ovr_prc && ovr_key && ovr_pre && ovr_an2);
    cov_wrap_c: cover property (run && timed && q.seq_idx == 3'h7 ##1 q.seq_idx == 3'h0);
    cov_restart_c: cover property (run && timed && restart ##1 !restart);
    cov_init_c: cover property (q.fsm == ST_LOAD && nv_i.init_sel == INIT_PRESET1);
    cov_fixed_c: cover property (run && tick && psel == 4'h8);

endmodule : ssel_top

//--- dv/ssel_top_bench.sv
// Self-checking bench for the speed reference source selector.
// Assumes shortened tick and dwell counts; the bench drives every port of the block itself.
`timescale 1ns/1ns
module ssel_top_bench;
    import ssel_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    localparam int          TCK    = 20;
    localparam logic [15:0] DWL    = 16'h0003;
    localparam int          SETTLE = 2 * TCK + 2;
    localparam logic [15:0] NV_KEY = 16'h1234;
    localparam logic [15:0] NV_PRE = 16'h0abc;

    logic          ref_clk_i;
    logic          nrst_i;
    ssel_bus_req_t bus;
    ssel_nv_t      nv;
    logic [15:0]   rdata;
    ssel_src_t     src_ind;
    logic [3:0]    pre_ind;
    logic [15:0]   key_val;
    logic [15:0]   pre1_val;
    int            n_errors;
    int            n_checks;
    logic [15:0]   rv;
    logic [15:0]   ev;

    ssel_top #(.TICK_CNT(TCK), .DWELL(DWL)) dut (
        .ref_clk_i                 (ref_clk_i),
        .nrst_i                    (nrst_i),
        .bus_i                     (bus),
        .rdata_o                   (rdata),
        .nv_i                      (nv),
        .active_source_indicator_o (src_ind),
        .active_preset_indicator_o (pre_ind),
        .keypad_reference_value_o  (key_val),
        .first_preset_value_o      (pre1_val)
    );

    initial ref_clk_i = 1'b0;
    always #20 ref_clk_i = ~ref_clk_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge ref_clk_i);
        bus.we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
        @(posedge ref_clk_i);
        bus.re <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : idle

    task automatic do_reset(input logic [1:0] sel);
        @(posedge ref_clk_i);
        nrst_i      <= 1'b0;
        nv.init_sel <= sel;
        repeat (6) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
    endtask : do_reset

    // Poll until the preset indicator shows the awaited value, bounded
    task automatic wait_pre(input logic [3:0] exp);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 60 && r[7:4] !== exp; i++) begin
            rd(OFS_STATUS, r);
        end
        chk({12'h000, r[7:4]}, {12'h000, exp});
    endtask : wait_pre

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_errors++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_i   = 1'b0;
        bus      = '0;
        nv       = '{keypad: NV_KEY, preset1: NV_PRE, init_sel: 2'h0};
        n_errors = 0;
        n_checks = 0;
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            ev = (s == 1) ? NV_KEY : (s == 2) ? NV_PRE : 16'h0000;
            rd(OFS_KEYPAD, rv);
            chk(rv, ev);
            chk(key_val, ev);
            chk(pre1_val, NV_PRE);
            rd(OFS_CFG, rv);
            chk(rv, {6'h00, s[1:0], 8'h00});
        end
        $display("Test power-up keypad value done");

        do_reset(2'h1);
        rd(OFS_STATUS, rv);
        chk(rv, 16'h0011);
        @(posedge ref_clk_i);
        #1 chk(rdata, 16'h0000);
        rd(4'hf, rv);
        chk(rv, 16'h0000);
        wr(OFS_CTRL, 16'hff00);
        rd(OFS_CTRL, rv);
        chk(rv, 16'h0000);
        wr(OFS_STATUS, 16'hffff);
        rd(OFS_STATUS, rv);
        chk(rv, 16'h0011);
        wr(OFS_KEYPAD, 16'h5a5a);
        rd(OFS_KEYPAD, rv);
        chk(rv, 16'h5a5a);
        chk(key_val, 16'h5a5a);
        wr(OFS_PRESET1, 16'h0c3c);
        rd(OFS_PRESET1, rv);
        chk(rv, 16'h0c3c);
        chk(pre1_val, 16'h0c3c);
        wr(OFS_CFG, 16'hffff);
        rd(OFS_CFG, rv);
        chk(rv, 16'h03ff);
        $display("Test register port done");

        wr(OFS_CFG, 16'h0000);
        for (int v = 0; v < 16; v++) begin
            wr(OFS_CTRL, v[15:0]);
            idle(SETTLE);
            ev = v[3] ? 16'h5 : v[2] ? 16'h4 : v[1] ? 16'h3 : v[0] ? 16'h2 : 16'h1;
            rd(OFS_STATUS, rv);
            chk({13'h0000, rv[2:0]}, ev);
            chk({13'h0000, src_ind}, ev);
        end
        $display("Test override priority done");

        wr(OFS_CTRL, 16'h0000);
        for (int r = 0; r < 8; r++) begin
            wr(OFS_CFG, 16'h0008 | r[15:0]);
            idle(SETTLE);
            ev = (r == 0) ? 16'h2 : (r > 5) ? 16'h5 : r[15:0];
            rd(OFS_STATUS, rv);
            chk({13'h0000, rv[2:0]}, ev);
        end
        $display("Test selector setting done");

        wr(OFS_CFG, 16'h0000);
        for (int s = 0; s < 8; s++) begin
            wr(OFS_CTRL, s[15:0] << 4);
            idle(SETTLE);
            rd(OFS_STATUS, rv);
            chk({12'h000, rv[7:4]}, s[15:0] + 16'h1);
            chk({12'h000, pre_ind}, s[15:0] + 16'h1);
        end
        $display("Test preset select bits done");

        for (int p = 1; p < 16; p++) begin
            if (p != 9) begin
                wr(OFS_CFG, p[15:0] << 4);
                idle(SETTLE);
                rd(OFS_STATUS, rv);
                chk({12'h000, rv[7:4]}, (p > 8) ? 16'h1 : p[15:0]);
                chk({12'h000, pre_ind}, (p > 8) ? 16'h1 : p[15:0]);
            end
        end
        $display("Test fixed preset selector done");

        wr(OFS_CFG, {8'h00, PSEL_TIMED, 4'h0});
        wr(OFS_CTRL, 16'h00f0);
        idle(SETTLE);
        rd(OFS_STATUS, rv);
        chk({12'h000, rv[7:4]}, 16'h1);
        idle(4 * TCK * 3);
        rd(OFS_STATUS, rv);
        chk({12'h000, rv[7:4]}, 16'h1);
        wr(OFS_CTRL, 16'h0000);
        for (int k = 2; k < 10; k++) begin
            wait_pre((k == 9) ? 4'h1 : k[3:0]);
        end
        $display("Test timed sequence done");
        conclude();
    end
endmodule : ssel_top_bench
